// [odt_pd_ctrl.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Termination response control around precharge power-down
// Assumes: WL >= 2 and WL-1 below history depth
// Notes:   Lead intervals are judged on a delayed copy of the inputs
//
// Functional notes
// RULE_01: ODT receiver stays active in power-down; controller issues no read or write.
// RULE_02: Frozen-DLL power-down uses asynchronous on and off delays of at least 2.
// RULE_03: Entry transition period only exists when the DLL-freeze bit is zero.
// RULE_04: Entry lead interval is WL-1 cycles before first CKE-low cycle.
// RULE_05: Entry period excludes lead start, includes end of CKE-low delay.
// RULE_06: Refresh in progress stretches entry period to later of refresh end.
// RULE_07: Turn-on in transition lies between async minimum and WL-2 sync latency.
// RULE_08: Turn-off in transition lies between async minimum and off-latency sync path.
// RULE_09: Exit period spans lead interval before CKE high to DLL exit delay after.
// RULE_10: Overlapping entry then exit periods merge into one uncertain window.
// RULE_11: Overlapping exit then entry periods merge into one uncertain window.
// RULE_12: Asynchronous path ignores additive latency.
// RULE_13: Controller keeps ODT stable in transition periods for determinism; the bench moves ODT inside exit windows in pd_exit and short_pd.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module odt_pd_ctrl (
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RST,
    input  wire logic       I_CKE,
    input  wire logic       I_ODT,
    input  wire logic       I_REFRESH,
    input  wire logic       I_DLL_FREEZE_N,
    input  wire logic [4:0] I_WL,
    input  wire logic [4:0] I_AL,
    output logic            O_RTT_ON,
    output logic            O_PD,
    output logic            O_TRANS,
    output logic            O_ASYNC
);
    ////////////////////////////////////////////////////////////////////////
    logic       cke_s;
    logic       cke_n_pin;
    logic       pd_req_s;
    logic       odt_s;
    logic       cke_d;
    logic [4:0] wl;
    logic       freeze_n;

    // CKE synced inverted: reset then leaves it at its idle high level, no false edge
    assign cke_n_pin = ~I_CKE;

    odt_sync3 u_cke (
        .i_clk   (I_CORE_CLK),
        .i_rst   (I_RST),
        .i_pin   (cke_n_pin),
        .o_level (pd_req_s)
    );
    assign cke_s = ~pd_req_s;

    odt_sync3 u_odt (
        .i_clk   (I_CORE_CLK),
        .i_rst   (I_RST),
        .i_pin   (I_ODT),
        .o_level (odt_s)
    );

    // Sync tap is WL-2, so turn-on/off takes WL cycles from synced ODT to output; AL is not added in this mode
    logic       sync_rtt;
    logic [4:0] sync_tap;
    assign sync_tap = wl - 5'h02; // see RULE_12

    odt_delay_line u_sync (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_RST),
        .i_din  (odt_s),
        .i_tap  (sync_tap),
        .o_dout (sync_rtt)
    );

    // Delayed CKE view so the lead interval can be seen before the edge
    logic       cke_lead;
    logic       pd_req_lead;
    logic [4:0] lead_tap;
    assign lead_tap = wl - 5'h01; // see RULE_04
    assign cke_lead = ~pd_req_lead;

    odt_delay_line u_lead (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_RST),
        .i_din  (pd_req_s),
        .i_tap  (lead_tap),
        .o_dout (pd_req_lead)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live CKE edges start the lead window; delayed edges are power-down edges
    logic      live_fall;
    logic      live_rise;
    logic      pd_fall;
    logic      pd_rise;
    logic      cke_lead_d;
    logic      next_cke_d;
    logic      next_cke_lead_d;

    always_comb begin
        live_fall       = cke_d & ~cke_s;
        live_rise       = ~cke_d & cke_s;
        pd_fall         = cke_lead_d & ~cke_lead;
        pd_rise         = ~cke_lead_d & cke_lead;
        next_cke_d      = cke_s;
        next_cke_lead_d = cke_lead;
    end

    ////////////////////////////////////////////////////////////////////////
    // Window counters: entry and exit tails, refresh in flight
    logic [7:0] entry_cnt;
    logic [7:0] exit_cnt;
    logic [7:0] rfc_cnt;
    logic       entry_lead;
    logic       exit_lead;
    logic [7:0] next_entry_cnt;
    logic [7:0] next_exit_cnt;
    logic [7:0] next_rfc_cnt;
    logic       next_entry_lead;
    logic       next_exit_lead;
    logic       entry_win;
    logic       exit_win;

    always_comb begin
        next_rfc_cnt    = rfc_cnt;
        next_entry_cnt  = entry_cnt;
        next_exit_cnt   = exit_cnt;
        next_entry_lead = entry_lead;
        next_exit_lead  = exit_lead;
        if (I_REFRESH) begin
            next_rfc_cnt = odt_pkg::RFC_CYC;
        end else if (rfc_cnt != 8'h00) begin
            next_rfc_cnt = rfc_cnt - 8'h01;
        end
        // Entry lead opens after its start point, only if DLL freezes
        if (live_fall && !freeze_n) begin
            next_entry_lead = 1'b1; // see RULE_03 RULE_05
        end else if (pd_fall) begin
            next_entry_lead = 1'b0;
        end
        if (pd_fall && !freeze_n) begin
            // Tail is CKE-low delay, or rest of refresh if longer
            next_entry_cnt = (rfc_cnt > odt_pkg::CPDED_CYC) ? rfc_cnt
                                                             : odt_pkg::CPDED_CYC; // see RULE_06
        end else if (entry_cnt != 8'h00) begin
            next_entry_cnt = entry_cnt - 8'h01; // see RULE_05
        end
        if (live_rise && !freeze_n) begin
            next_exit_lead = 1'b1; // see RULE_09
        end else if (pd_rise) begin
            next_exit_lead = 1'b0;
        end
        if (pd_rise && !freeze_n) begin
            next_exit_cnt = odt_pkg::XPDLL_CYC; // see RULE_09
        end else if (exit_cnt != 8'h00) begin
            next_exit_cnt = exit_cnt - 8'h01;
        end
    end

    // Windows are independent flags: their union covers both overlap orders
    assign entry_win = entry_lead | (entry_cnt != 8'h00);
    assign exit_win  = exit_lead | (exit_cnt != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Mode and termination output
    odt_pkg::pd_state_e state;
    odt_pkg::pd_state_e next_state;
    logic               next_rtt;
    logic               async_on_d;
    logic               next_async_on_d;
    logic               trans;

    assign trans = entry_win | exit_win; // see RULE_10 RULE_11

    always_comb begin
        next_state = state;
        case (state)
            odt_pkg::ST_IDLE:  if (!cke_lead) next_state = odt_pkg::ST_PD;
            odt_pkg::ST_PD:    if (cke_lead) next_state = odt_pkg::ST_IDLE;
            default:           next_state = odt_pkg::ST_IDLE;
        endcase
        // Async path: ODT sampled, one cycle (>= 2 ns) later, no AL
        next_async_on_d = odt_s; // see RULE_02 RULE_12
        if (state == odt_pkg::ST_PD && !freeze_n && !trans) begin
            next_rtt = async_on_d; // see RULE_02 RULE_01
        end else if (trans) begin
            // Either response allowed: on with the first path, off with the last
            next_rtt = async_on_d | sync_rtt; // see RULE_07 RULE_08
        end else begin
            next_rtt = sync_rtt;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            cke_d      <= 1'b1;
            cke_lead_d <= 1'b1;
            rfc_cnt    <= 8'h00;
            entry_cnt  <= 8'h00;
            exit_cnt   <= 8'h00;
            entry_lead <= 1'b0;
            exit_lead  <= 1'b0;
            state      <= odt_pkg::ST_IDLE;
            async_on_d <= 1'b0;
            O_RTT_ON   <= 1'b0;
            O_PD       <= 1'b0;
            O_TRANS    <= 1'b0;
            O_ASYNC    <= 1'b0;
        end else begin
            cke_d      <= next_cke_d;
            cke_lead_d <= next_cke_lead_d;
            rfc_cnt    <= next_rfc_cnt;
            entry_cnt  <= next_entry_cnt;
            exit_cnt   <= next_exit_cnt;
            entry_lead <= next_entry_lead;
            exit_lead  <= next_exit_lead;
            state      <= next_state;
            async_on_d <= next_async_on_d;
            O_RTT_ON   <= next_rtt;
            O_PD       <= (next_state == odt_pkg::ST_PD);
            O_TRANS    <= trans;
            O_ASYNC    <= (state == odt_pkg::ST_PD) && !freeze_n && !trans;
        end
    end

    // Mode bits caught after reset release, not under reset
    logic rst_seen;
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            rst_seen <= 1'b0;
            wl       <= odt_pkg::WL_RESET;
            freeze_n <= 1'b1;
        end else begin
            rst_seen <= 1'b1;
            wl       <= I_WL;
            freeze_n <= I_DLL_FREEZE_N;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_fall_edge;
        live_fall && !freeze_n;
    endsequence

    property p_entry_opens;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        s_fall_edge |=> entry_win;
    endproperty
    a_entry_opens: assert property (p_entry_opens) // see RULE_05
        else $error("entry window did not open");

    property p_no_entry_unfrozen;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (freeze_n && $past(freeze_n) && !entry_win && !exit_win) |=> !entry_win;
    endproperty
    a_no_entry_unfrozen: assert property (p_no_entry_unfrozen) // see RULE_03
        else $error("entry window with DLL kept on");

    property p_tail_len;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (pd_fall && !freeze_n && rfc_cnt <= odt_pkg::CPDED_CYC) |=> entry_cnt == odt_pkg::CPDED_CYC;
    endproperty
    a_tail_len: assert property (p_tail_len) // see RULE_05
        else $error("entry tail length wrong");

    property p_rfc_stretch;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (pd_fall && !freeze_n && rfc_cnt > odt_pkg::CPDED_CYC) |=> entry_cnt == $past(rfc_cnt);
    endproperty
    a_rfc_stretch: assert property (p_rfc_stretch) // see RULE_06
        else $error("refresh did not stretch entry");

    property p_exit_tail;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (pd_rise && !freeze_n) |=> exit_cnt == odt_pkg::XPDLL_CYC;
    endproperty
    a_exit_tail: assert property (p_exit_tail) // see RULE_09
        else $error("exit tail length wrong");

    property p_trans_union;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (entry_win || exit_win) |=> O_TRANS;
    endproperty
    a_trans_union: assert property (p_trans_union) // see RULE_10
        else $error("overlap window dropped");

    property p_async_follow;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (O_ASYNC && $stable(odt_s)) ##1 (O_ASYNC && $stable(odt_s)) ##1 O_ASYNC
            |-> O_RTT_ON == $past(odt_s);
    endproperty
    a_async_follow: assert property (p_async_follow) // see RULE_02
        else $error("async termination lags ODT");

    property p_sync_tap;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        rst_seen |-> sync_tap == 5'(wl - 5'h02);
    endproperty
    a_sync_tap: assert property (p_sync_tap) // see RULE_12
        else $error("sync latency uses AL");

    property p_trans_bounds;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (O_TRANS && async_on_d && sync_rtt) |=> O_RTT_ON;
    endproperty
    a_trans_bounds: assert property (p_trans_bounds) // see RULE_07
        else $error("turn-on beyond both paths");

    property p_trans_off;
        @(posedge I_CORE_CLK) disable iff (I_RST)
        (trans && !async_on_d && !sync_rtt) |=> !O_RTT_ON;
    endproperty
    a_trans_off: assert property (p_trans_off) // see RULE_08
        else $error("turn-off beyond both paths");

endmodule // odt_pd_ctrl

// [odt_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the power-down termination control
// Assumes: Single core clock at 25 MHz
// Notes:   Latencies in clock cycles, times in ns
//////////////////////////////////////////////////////////////////////////////
package odt_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 40;
    // Asynchronous turn-on / turn-off minimum delays
    localparam int unsigned AONPD_MIN_NS      = 2;
    localparam int unsigned AOFPD_MIN_NS      = 2;
    localparam int unsigned AONPD_MIN_CYC_RAW =
        (AONPD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AOFPD_MIN_CYC_RAW =
        (AOFPD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  AONPD_MIN_CYC     =
        4'(AONPD_MIN_CYC_RAW < 1 ? 1 : AONPD_MIN_CYC_RAW);
    localparam logic [3:0]  AOFPD_MIN_CYC     =
        4'(AOFPD_MIN_CYC_RAW < 1 ? 1 : AOFPD_MIN_CYC_RAW);

    localparam logic [4:0]  WL_RESET          = 5'h05;
    localparam logic [7:0]  CPDED_CYC         = 8'h01;
    localparam logic [7:0]  XPDLL_CYC         = 8'h0A;
    localparam logic [7:0]  RFC_CYC           = 8'h40;
    localparam int          HIST_W            = 16;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ENTRY = 2'b01,
        ST_PD    = 2'b10,
        ST_EXIT  = 2'b11
    } pd_state_e;

    typedef struct packed {
        logic cke;
        logic odt;
        logic refresh;
        logic rdwr;
    } ctrl_in_s;

    typedef struct packed {
        logic pd;
        logic trans;
        logic async_mode;
    } mode_out_s;

endpackage

// [odt_sync3.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to the core clock
// Notes:   Output changes once stages two and three agree
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module odt_sync3 (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb begin
        next_stage = {stage[1:0], i_pin};
        next_level = (stage[2] == stage[1]) ? stage[2] : o_level;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage   <= 3'h0;
            o_level <= 1'b0;
        end else begin
            stage   <= next_stage;
            o_level <= next_level;
        end
    end
endmodule // odt_sync3

// [odt_delay_line.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: History of a sampled pin level, for the synchronous ODT path and the CKE lead view
// Assumes: Tap index below HIST_W
// Notes:   Registered tap output
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module odt_delay_line (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_din,
    input  wire logic [4:0] i_tap,
    output logic            o_dout
);
    logic [odt_pkg::HIST_W-1:0] hist;
    logic [odt_pkg::HIST_W-1:0] next_hist;
    logic                       next_dout;

    always_comb begin
        next_hist = {hist[odt_pkg::HIST_W-2:0], i_din};
        next_dout = (i_tap == 5'h00) ? i_din : hist[4'(i_tap - 5'h01)];
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hist   <= '0;
            o_dout <= 1'b0;
        end else begin
            hist   <= next_hist;
            o_dout <= next_dout;
        end
    end
endmodule // odt_delay_line

// [odt_ctrl_model.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Memory controller model driving the power-down pins
// Assumes: Pins change only just after a rising edge of the core clock
// Notes:   Has no read or write command output at all
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module odt_ctrl_model (
    input  wire logic i_clk,
    output logic      o_cke,
    output logic      o_odt,
    output logic      o_refresh
);
    // No read or write path, so none can reach a powered-down device
    initial begin
        o_cke     = 1'b1;
        o_odt     = 1'b0;
        o_refresh = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Bench calls these outside transition windows unless a test means
    // to probe the uncertain response
    task automatic set_odt(input logic v);
        @(posedge i_clk);
        o_odt <= v;
    endtask

    task automatic set_cke(input logic v);
        @(posedge i_clk);
        o_cke <= v;
    endtask

    task automatic refresh();
        @(posedge i_clk);
        o_refresh <= 1'b1;
        @(posedge i_clk);
        o_refresh <= 1'b0;
    endtask
endmodule // odt_ctrl_model

// [testbench.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the power-down termination control
// Assumes: Pin synchronisers add three to four cycles
// Notes:   Latency windows are wide enough to cover the synchronisers
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module testbench;
    typedef struct { logic val; int lo; int hi; } note_s;
    logic       clk        = 1'b0;
    logic       rst        = 1'b1;
    logic       cke;
    logic       odt;
    logic       refr;
    logic       rtt;
    logic       pd;
    logic       trans;
    logic       async_on;
    logic       freeze_n;
    logic [4:0] wl;
    logic [4:0] al;
    logic       rtt_prev   = 1'b0;
    logic       trans_prev = 1'b0;
    int         cyc, segs, err_total, compares, seed, t0, f, k;
    int         wli, cped, xpd, rfc;
    note_s      q[$];
    note_s      n;

    always #20 clk = ~clk;

    odt_ctrl_model odt_ctrl_model_i (
        .i_clk     (clk),
        .o_cke     (cke),
        .o_odt     (odt),
        .o_refresh (refr)
    );

    odt_pd_ctrl odt_pd_ctrl_i (
        .I_CORE_CLK     (clk),
        .I_RST          (rst),
        .I_CKE          (cke),
        .I_ODT          (odt),
        .I_REFRESH      (refr),
        .I_DLL_FREEZE_N (freeze_n),
        .I_WL           (wl),
        .I_AL           (al),
        .O_RTT_ON       (rtt),
        .O_PD           (pd),
        .O_TRANS        (trans),
        .O_ASYNC        (async_on)
    );

    //////////////////////////////////////////////////////////////////////////
    // Monitor: each termination change consumes the oldest note
    always @(posedge clk) begin
        cyc        <= cyc + 1;
        rtt_prev   <= rtt;
        trans_prev <= trans;
        if (trans === 1'b1 && trans_prev !== 1'b1)
            segs <= segs + 1;
        if (!rst && rtt !== rtt_prev) begin
            if (q.size() == 0) begin
                `CHK("rtt change unasked", 1'b0, 1'b1)
            end else begin
                n = q.pop_front();
                `CHK("rtt value", n.val, rtt)
                `CHK("rtt latency", 1'b1, cyc >= n.lo && cyc <= n.hi)
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // Note is stamped after the launching edge has been counted
    task automatic odt_to(input logic v, input int lo, input int hi);
        odt_ctrl_model_i.set_odt(v);
        #1;
        q.push_back('{v, cyc + lo, cyc + hi});
    endtask

    task automatic trans_span(output int rise, output int fall);
        int c;
        c = 0;
        while (trans !== 1'b1 && c < 60) begin
            step(1);
            c++;
        end
        rise = cyc;
        while (trans === 1'b1 && c < 600) begin
            step(1);
            c++;
        end
        fall = cyc;
    endtask

    task automatic stop_test();
        `CHK("rtt changes pending", 0, q.size())
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        seed = 38027;
        wli  = 8 + ($random(seed) & 3);
        cped = int'(odt_pkg::CPDED_CYC);
        xpd  = int'(odt_pkg::XPDLL_CYC);
        rfc  = int'(odt_pkg::RFC_CYC);
        freeze_n <= 1'b0;
        wl       <= 5'(wli);
        // Large additive latency would show if the async path used it
        al       <= 5'(12 + ($random(seed) & 15));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        step(6);
        // Synchronous response while idle, ODT moved outside windows
        odt_to(1'b1, wli - 2, wli + 8);
        step(wli + 12);
        odt_to(1'b0, wli - 2, wli + 8);
        step(wli + 12);
        $display("test sync_idle done");
        // Entry with frozen DLL, then async response
        odt_ctrl_model_i.set_cke(1'b0);
        trans_span(t0, f);
        `CHK("entry span", 1'b1, (f - t0) >= wli - 3 + cped && (f - t0) <= wli + 1 + cped)
        step(4);
        `CHK("power-down flag", 1'b1, pd)
        `CHK("async in power-down", 1'b1, async_on)
        odt_to(1'b1, 2, 10);
        step(14);
        odt_to(1'b0, 2, 10);
        step(14);
        $display("test pd_entry_async done");
        // Exit with ODT moved inside the exit window
        odt_ctrl_model_i.set_cke(1'b1);
        #1;
        t0 = cyc;
        odt_to(1'b1, 2, wli + 8);
        trans_span(k, f);
        `CHK("exit span", 1'b1, (f - t0) >= xpd && (f - t0) <= xpd + wli + 8)
        step(2);
        `CHK("sync after exit", 1'b0, async_on)
        $display("test pd_exit done");
        // Refresh in progress stretches the entry window
        odt_ctrl_model_i.refresh();
        #1;
        t0 = cyc;
        odt_ctrl_model_i.set_cke(1'b0);
        trans_span(k, f);
        `CHK("refresh stretch", 1'b1, (f - t0) >= rfc - 2 && (f - t0) <= rfc + wli + 8)
        odt_ctrl_model_i.set_cke(1'b1);
        step(wli + xpd + 20);
        $display("test refresh_entry done");
        // DLL kept running: no window, no async mode
        @(posedge clk) freeze_n <= 1'b1;
        step(2);
        k = segs;
        odt_ctrl_model_i.set_cke(1'b0);
        step(30);
        `CHK("no window with dll on", 0, segs - k)
        `CHK("sync with dll on", 1'b0, async_on)
        odt_ctrl_model_i.set_cke(1'b1);
        step(30);
        @(posedge clk) freeze_n <= 1'b0;
        step(2);
        $display("test dll_on done");
        // Very short power-down: entry and exit windows merge
        k = segs;
        odt_ctrl_model_i.set_cke(1'b0);
        step(2);
        odt_ctrl_model_i.set_cke(1'b1);
        odt_to(1'b0, 2, wli + 8);
        step(wli + xpd + 30);
        `CHK("merged short pd", 1, segs - k)
        $display("test short_pd done");
        // Very short idle: exit and next entry windows merge
        odt_ctrl_model_i.set_cke(1'b0);
        step(wli + 20);
        k = segs;
        odt_ctrl_model_i.set_cke(1'b1);
        step(2);
        odt_ctrl_model_i.set_cke(1'b0);
        step(wli + xpd + 30);
        `CHK("merged short idle", 1, segs - k)
        odt_ctrl_model_i.set_cke(1'b1);
        step(wli + xpd + 30);
        $display("test short_idle done");
        stop_test();
    end
endmodule // testbench
